// ===== src/hbcr_pkg.sv
// host bus config registers: shared constants, field positions and types
// assumes a 16-bit register view, 10 MHz system clock, microwire serial rom
package hbcr_pkg;
  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int ROM_SK_HALF_NS  = 500;
  localparam int ROM_SK_HALF_CYC = (ROM_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // banks and byte offsets within a bank
  localparam logic [5:0] BANK_BUS   = 6'h00;
  localparam logic [5:0] BANK_STA   = 6'h02;
  localparam logic [5:0] BANK_CHIP  = 6'h03;
  localparam logic [5:0] BANK_TXQ   = 6'h10;
  localparam logic [3:0] OFF_0      = 4'h0;
  localparam logic [3:0] OFF_2      = 4'h2;
  localparam logic [3:0] OFF_4      = 4'h4;
  localparam logic [3:0] OFF_6      = 4'h6;
  localparam logic [3:0] OFF_8      = 4'h8;
  localparam logic [3:0] OFF_BANKSEL = 4'he;
  // reset values
  localparam logic [15:0] BASE_DEFAULT = 16'h0300;
  localparam logic [1:0]  SPEED_FAST   = 2'h0;
  localparam logic [1:0]  SPEED_SLOW   = 2'h3;
  localparam logic [11:0] WMARK_3K     = 12'hc00;
  localparam logic [11:0] WMARK_2K     = 12'h800;
  // field positions
  localparam int P_BASE      = 5;
  localparam int W_BASE      = 11;
  localparam int P_WMARK     = 12;
  localparam int P_BAD_FLAG  = 15;
  localparam int P_BAD_VAL   = 11;
  localparam int P_CLASH     = 10;
  localparam int P_BURST     = 12;
  localparam int P_SPEED     = 0;
  localparam int P_SW_ACC    = 4;
  localparam int P_ROM_DI    = 3;
  localparam int P_ROM_CTL   = 0;
  localparam int P_TXM_DONE  = 12;
  localparam int P_TXM_FAIL  = 11;
  localparam int P_RXM_DONE  = 4;
  localparam int P_RXM_FAIL  = 3;
  localparam int P_SOFT_RST  = 0;
  localparam int P_BUS16     = 0;
  localparam int P_CFG_SPEED = 1;
  localparam int P_TXCTL     = 0;
  localparam int P_TX_PAUSE  = 3;
  localparam int P_TX_PAD    = 2;
  localparam int P_TX_CRC    = 1;
  localparam int P_TX_RUN    = 0;
  // serial rom words and command
  localparam logic [5:0] ROM_W_BASE = 6'h00;
  localparam logic [5:0] ROM_W_MACL = 6'h01;
  localparam logic [5:0] ROM_W_MACM = 6'h02;
  localparam logic [5:0] ROM_W_MACH = 6'h03;
  localparam logic [5:0] ROM_W_CFG  = 6'h06;
  localparam logic [2:0] ROM_OP_READ = 3'h6;
  localparam logic [4:0] ROM_CMD_LAST  = 5'h08;
  localparam logic [4:0] ROM_DATA_LAST = 5'h0f;
  localparam logic [2:0] ROM_SEL_LAST  = 3'h4;
  localparam logic [1:0] BOOT_WAIT     = 2'h2;
  typedef enum logic [1:0] {
    HBCR_LD_IDLE = 2'b00,
    HBCR_LD_CMD  = 2'b01,
    HBCR_LD_DATA = 2'b10,
    HBCR_LD_GAP  = 2'b11
  } hbcr_ld_state_t;
endpackage : hbcr_pkg

// ===== src/hbcr_rom_loader.sv
// serial rom loader: reads the boot words one after another over microwire
// assumes the data-in level is already synchronised by the caller
`timescale 1ns/1ps
module hbcr_rom_loader import hbcr_pkg::*; #(
  parameter int HALF_CYC = ROM_SK_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // control
  input  wire logic        start_in,
  output logic             busy_out,
  // rom pins
  input  wire logic        rom_di_in,
  output logic             rom_cs_out,
  output logic             rom_sk_out,
  output logic             rom_do_out,
  // loaded word
  output logic [15:0]      word_out,
  output logic [5:0]       word_addr_out,
  output logic             word_valid_out
);
  typedef struct packed {
    hbcr_ld_state_t state;
    logic [7:0]     div;
    logic [4:0]     bit_cnt;
    logic [2:0]     sel;
    logic           sk;
    logic           cs;
    logic [15:0]    shreg;
    logic           valid;
  } hbcr_ld_t;

  hbcr_ld_t st;
  hbcr_ld_t next_st;

  // word order of the boot sequence
  function automatic logic [5:0] word_addr(input logic [2:0] sel);
    unique case (sel)
      3'h0:    word_addr = ROM_W_BASE;
      3'h1:    word_addr = ROM_W_MACL;
      3'h2:    word_addr = ROM_W_MACM;
      3'h3:    word_addr = ROM_W_MACH;
      default: word_addr = ROM_W_CFG;
    endcase
  endfunction : word_addr

  // read command sits in the top bits and shifts out msb first
  function automatic logic [15:0] cmd_word(input logic [2:0] sel);
    cmd_word = {ROM_OP_READ, word_addr(sel), 7'h00};
  endfunction : cmd_word

  // sequencer: sample on rising clock edge, advance on falling
  always_comb begin
    logic tick;
    tick = (st.div == 8'(HALF_CYC - 1));
    next_st = st;
    next_st.valid = 1'b0;
    next_st.div = tick ? 8'h00 : st.div + 8'h01;
    unique case (st.state)
      HBCR_LD_IDLE: begin
        next_st.div = 8'h00;
        if (start_in) begin
          next_st.sel = 3'h0;
          next_st.cs = 1'b1;
          next_st.sk = 1'b0;
          next_st.bit_cnt = 5'h00;
          next_st.shreg = cmd_word(3'h0);
          next_st.state = HBCR_LD_CMD;
        end
      end
      HBCR_LD_CMD: begin
        if (tick && !st.sk) begin
          next_st.sk = 1'b1;
        end else if (tick) begin
          next_st.sk = 1'b0;
          next_st.shreg = {st.shreg[14:0], 1'b0};
          next_st.bit_cnt = st.bit_cnt + 5'h01;
          if (st.bit_cnt == ROM_CMD_LAST) begin
            next_st.bit_cnt = 5'h00;
            next_st.state = HBCR_LD_DATA;
          end
        end
      end
      HBCR_LD_DATA: begin
        if (tick && !st.sk) begin
          next_st.sk = 1'b1;
          next_st.shreg = {st.shreg[14:0], rom_di_in};
        end else if (tick) begin
          next_st.sk = 1'b0;
          next_st.bit_cnt = st.bit_cnt + 5'h01;
          if (st.bit_cnt == ROM_DATA_LAST) begin
            next_st.valid = 1'b1;
            next_st.cs = 1'b0;
            next_st.state = HBCR_LD_GAP;
          end
        end
      end
      HBCR_LD_GAP: begin
        if (tick && st.sel == ROM_SEL_LAST) begin
          next_st.state = HBCR_LD_IDLE;
        end else if (tick) begin
          next_st.sel = st.sel + 3'h1;
          next_st.cs = 1'b1;
          next_st.bit_cnt = 5'h00;
          next_st.shreg = cmd_word(st.sel + 3'h1);
          next_st.state = HBCR_LD_CMD;
        end
      end
    endcase
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign busy_out       = (st.state != HBCR_LD_IDLE);
  assign rom_cs_out     = st.cs;
  assign rom_sk_out     = st.sk;
  assign rom_do_out     = (st.state == HBCR_LD_CMD) & st.shreg[15];
  assign word_out       = st.shreg;
  assign word_addr_out  = word_addr(st.sel);
  assign word_valid_out = st.valid;
endmodule : hbcr_rom_loader

// ===== src/hbcr_regs.sv
// host bus config registers: base decode, bus errors, station address,
// serial rom access and boot load, soft reset and transmit control/status
// assumes host bus strobes are synchronous to SYS_CLK_IN, one cycle each
`timescale 1ns/1ps
module hbcr_regs import hbcr_pkg::*; #(
  parameter logic DEFAULT_BUS16 = 1'b1
) (
  // clock, reset, enable
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CE_IN,
  // straps
  input  wire logic        ROM_LOAD_ENABLE_PIN_IN,
  // host bus
  input  wire logic [15:0] BUS_ADDR_IN,
  input  wire logic [3:0]  BUS_BE_IN,
  input  wire logic [15:0] BUS_WDATA_IN,
  input  wire logic        BUS_WR_IN,
  input  wire logic        BUS_RD_IN,
  input  wire logic        BUS_SYNC_XFER_IN,
  input  wire logic        BUS_ASYNC_XFER_IN,
  output logic [15:0]      BUS_RDATA_OUT,
  output logic             BUS_HIT_OUT,
  // serial rom pins
  input  wire logic        ROM_SERIAL_IN_PIN_IN,
  output logic             ROM_SERIAL_OUT_PIN_OUT,
  output logic             ROM_SERIAL_CLOCK_PIN_OUT,
  output logic             ROM_SELECT_PIN_OUT,
  // self-test results
  input  wire logic        TX_MEM_TEST_DONE_IN,
  input  wire logic        TX_MEM_TEST_FAILED_IN,
  input  wire logic        RX_MEM_TEST_DONE_IN,
  input  wire logic        RX_MEM_TEST_FAILED_IN,
  // queue manager
  input  wire logic        SWITCH_PAUSE_GLOBAL_IN,
  input  wire logic        RX_FIFO_AT_THRESH_IN,
  input  wire logic        TX_FRAME_BUSY_IN,
  input  wire logic        TX_DONE_IN,
  input  wire logic [5:0]  TX_DONE_TAG_IN,
  output logic             TX_SEND_PAUSE_OUT,
  output logic             TX_PAD_ENABLE_OUT,
  output logic             TX_CHECKSUM_APPEND_OUT,
  output logic             TRANSMIT_RUN_OUT,
  output logic [11:0]      RX_HIGH_WATERMARK_OUT,
  // chip configuration
  output logic [2:0]       BURST_SIZE_OUT,
  output logic [1:0]       INTERNAL_BUS_SPEED_OUT,
  output logic             BUS_WIDTH_16_OUT,
  output logic             SOFT_RESET_OUT,
  output logic             LOADING_OUT
);
  typedef struct packed {
    logic [W_BASE-1:0] base;
    logic              wm_sel;
    logic              bad_flag;
    logic [3:0]        bad_val;
    logic              clash;
    logic [2:0]        burst;
    logic [15:0]       mac_lo;
    logic [15:0]       mac_mid;
    logic [15:0]       mac_hi;
    logic [1:0]        speed;
    logic              sw_acc;
    logic [2:0]        rom_ctl;
    logic              soft_rst;
    logic              bus16;
    logic [3:0]        txctl;
    logic [5:0]        tx_tag;
    logic              tx_run;
    logic [5:0]        bank;
    logic [15:0]       rdata;
    logic [1:0]        boot;
    logic              loading;
    logic              start;
    logic              en_s1;
    logic              en_s2;
    logic              di_s1;
    logic              di_s2;
  } hbcr_regs_t;

  hbcr_regs_t  st;
  hbcr_regs_t  next_st;
  logic        ld_busy;
  logic        ld_cs;
  logic        ld_sk;
  logic        ld_do;
  logic [15:0] ld_word;
  logic [5:0]  ld_addr;
  logic        ld_valid;
  logic [10:0] eff_base;
  logic        hit;
  logic        legal;
  logic [3:0]  off;
  logic [15:0] rv;
  logic [15:0] wv;

  // byte-lane merge so byte writes keep the other half
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0]  lanes);
    merge = {lanes[1] ? wd[15:8] : old[15:8], lanes[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  // lane patterns a 16/32-bit host may present: bytes, words, dword
  function automatic logic be_legal(input logic [3:0] be);
    unique case (be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_legal = 1'b1;
      default:                                  be_legal = 1'b0;
    endcase
  endfunction : be_legal

  // boot loader walks the rom words once after reset if the strap asks for it
  hbcr_rom_loader u_loader (
    .clk_in         (SYS_CLK_IN),
    .rst_n_in       (RST_N_IN),
    .ce_in          (CE_IN),
    .start_in       (st.start),
    .busy_out       (ld_busy),
    .rom_di_in      (st.di_s2),
    .rom_cs_out     (ld_cs),
    .rom_sk_out     (ld_sk),
    .rom_do_out     (ld_do),
    .word_out       (ld_word),
    .word_addr_out  (ld_addr),
    .word_valid_out (ld_valid)
  );

  // address decode; default base used until the boot load ends
  assign eff_base = st.loading ? BASE_DEFAULT[15:P_BASE] : st.base;
  assign hit   = (BUS_ADDR_IN[15:P_BASE] == eff_base);
  assign legal = be_legal(BUS_BE_IN);
  assign off   = {BUS_ADDR_IN[3:1], 1'b0};

  // read view of the addressed register; unmapped locations read zero
  always_comb begin
    rv = 16'h0000;
    if (off == OFF_BANKSEL) begin
      rv = {10'h000, st.bank};
    end else begin
      unique case (st.bank)
        BANK_BUS: begin
          unique case (off)
            OFF_0: rv = {st.base, 5'h00};
            OFF_4: rv[P_WMARK] = st.wm_sel;
            OFF_6: begin
              rv[P_BAD_FLAG] = st.bad_flag;
              rv[P_BAD_VAL +: 4] = st.bad_val;
              rv[P_CLASH] = st.clash;
            end
            OFF_8: rv[P_BURST +: 3] = st.burst;
            default: rv = 16'h0000;
          endcase
        end
        BANK_STA: begin
          unique case (off)
            OFF_0:   rv = st.mac_lo;
            OFF_2:   rv = st.mac_mid;
            OFF_4:   rv = st.mac_hi;
            default: rv = 16'h0000;
          endcase
        end
        BANK_CHIP: begin
          unique case (off)
            OFF_0: rv[P_SPEED +: 2] = st.speed;
            OFF_2: begin
              rv[P_SW_ACC] = st.sw_acc;
              rv[P_ROM_DI] = st.di_s2;
              rv[P_ROM_CTL +: 3] = st.rom_ctl;
            end
            OFF_4: begin
              rv[P_TXM_DONE] = TX_MEM_TEST_DONE_IN;
              rv[P_TXM_FAIL] = TX_MEM_TEST_FAILED_IN;
              rv[P_RXM_DONE] = RX_MEM_TEST_DONE_IN;
              rv[P_RXM_FAIL] = RX_MEM_TEST_FAILED_IN;
            end
            OFF_6: rv[P_SOFT_RST] = st.soft_rst;
            OFF_8: rv[P_BUS16] = st.bus16;
            default: rv = 16'h0000;
          endcase
        end
        BANK_TXQ: begin
          unique case (off)
            OFF_0:   rv[P_TXCTL +: 4] = st.txctl;
            OFF_2:   rv[5:0] = st.tx_tag;
            default: rv = 16'h0000;
          endcase
        end
        default: rv = 16'h0000;
      endcase
    end
  end

  assign wv = merge(rv, BUS_WDATA_IN, BUS_BE_IN[1:0]);

  // next-state: host writes, hardware events, boot load
  always_comb begin
    logic acc;
    logic wr;
    acc = hit & (BUS_WR_IN | BUS_RD_IN);
    wr  = hit & BUS_WR_IN & legal;
    next_st = st;
    // two-flop synchronisers for the strap and the rom data pin
    next_st.en_s1 = ROM_LOAD_ENABLE_PIN_IN;
    next_st.en_s2 = st.en_s1;
    next_st.di_s1 = ROM_SERIAL_IN_PIN_IN;
    next_st.di_s2 = st.di_s1;
    next_st.start = 1'b0;
    // strap is trusted only once its synchroniser has filled
    if (st.boot != BOOT_WAIT + 2'h1) begin
      next_st.boot = st.boot + 2'h1;
      if (st.boot == BOOT_WAIT && st.en_s2) begin
        next_st.start = 1'b1;
        next_st.loading = 1'b1;
      end
    end
    if (st.loading && !st.start && !ld_busy) begin
      next_st.loading = 1'b0;
    end
    if (BUS_RD_IN && hit) begin
      next_st.rdata = rv;
    end
    // host writes; rom contents are never touched by any of these
    if (wr) begin
      if (off == OFF_BANKSEL) begin
        next_st.bank = wv[5:0];
      end else begin
        unique case (st.bank)
          BANK_BUS: begin
            unique case (off)
              OFF_0: next_st.base = wv[15:P_BASE];
              OFF_4: next_st.wm_sel = wv[P_WMARK];
              OFF_8: next_st.burst = wv[P_BURST +: 3];
              default: next_st.burst = st.burst;
            endcase
          end
          BANK_STA: begin
            unique case (off)
              OFF_0: next_st.mac_lo = wv;
              OFF_2: next_st.mac_mid = wv;
              OFF_4: next_st.mac_hi = wv;
              default: next_st.mac_lo = st.mac_lo;
            endcase
          end
          BANK_CHIP: begin
            unique case (off)
              OFF_0: next_st.speed = wv[P_SPEED +: 2];
              OFF_2: begin
                next_st.sw_acc = wv[P_SW_ACC];
                next_st.rom_ctl = wv[P_ROM_CTL +: 3];
              end
              OFF_6: next_st.soft_rst = wv[P_SOFT_RST];
              default: next_st.speed = st.speed;
            endcase
          end
          BANK_TXQ: begin
            if (off == OFF_0) begin
              next_st.txctl = wv[P_TXCTL +: 4];
            end
          end
          default: next_st.bank = st.bank;
        endcase
      end
    end
    // error flags: write one clears, a new event in the same cycle wins
    if (wr && st.bank == BANK_BUS && off == OFF_6 && BUS_BE_IN[1]) begin
      if (BUS_WDATA_IN[P_BAD_FLAG]) next_st.bad_flag = 1'b0;
      if (BUS_WDATA_IN[P_CLASH])    next_st.clash = 1'b0;
    end
    if (acc && !legal) begin
      next_st.bad_flag = 1'b1;
      next_st.bad_val  = BUS_BE_IN;
    end
    if (BUS_SYNC_XFER_IN && BUS_ASYNC_XFER_IN) begin
      next_st.clash = 1'b1;
    end
    // boot words land in the active registers only
    if (ld_valid) begin
      unique case (ld_addr)
        ROM_W_BASE: next_st.base = ld_word[15:P_BASE];
        ROM_W_MACL: next_st.mac_lo = ld_word;
        ROM_W_MACM: next_st.mac_mid = ld_word;
        ROM_W_MACH: next_st.mac_hi = ld_word;
        ROM_W_CFG: begin
          next_st.speed = ld_word[P_CFG_SPEED] ? SPEED_SLOW : SPEED_FAST;
          next_st.bus16 = ld_word[P_BUS16];
        end
        default: next_st.base = st.base;
      endcase
    end
    // run drops only once the frame in flight has gone; soft reset stops it
    next_st.tx_run = st.txctl[P_TX_RUN] | (st.tx_run & TX_FRAME_BUSY_IN);
    if (st.soft_rst) begin
      next_st.tx_run = 1'b0;
    end
    if (TX_DONE_IN) begin
      next_st.tx_tag = TX_DONE_TAG_IN;
    end
  end

  // state register; reset values give the no-rom defaults
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st         <= '0;
      st.base    <= BASE_DEFAULT[15:P_BASE];
      st.speed   <= SPEED_FAST;
      st.bus16   <= DEFAULT_BUS16;
    end else if (CE_IN) begin
      st <= next_st;
    end
  end

  // rom pins: software bit-bang or the boot loader, never both
  assign ROM_SERIAL_OUT_PIN_OUT   = st.sw_acc ? st.rom_ctl[2] : ld_do;
  assign ROM_SERIAL_CLOCK_PIN_OUT = st.sw_acc ? st.rom_ctl[1] : ld_sk;
  assign ROM_SELECT_PIN_OUT       = st.sw_acc ? st.rom_ctl[0] : ld_cs;

  // host side outputs
  assign BUS_RDATA_OUT = st.rdata;
  assign BUS_HIT_OUT   = hit;

  // queue manager controls; pause needs both enables and the fifo at its threshold
  assign TX_SEND_PAUSE_OUT = st.txctl[P_TX_PAUSE] & SWITCH_PAUSE_GLOBAL_IN
                             & RX_FIFO_AT_THRESH_IN;
  assign TX_PAD_ENABLE_OUT      = st.txctl[P_TX_PAD];
  assign TX_CHECKSUM_APPEND_OUT = st.txctl[P_TX_CRC];
  assign TRANSMIT_RUN_OUT       = st.tx_run;
  assign RX_HIGH_WATERMARK_OUT  = st.wm_sel ? WMARK_2K : WMARK_3K;

  // chip configuration
  assign BURST_SIZE_OUT         = st.burst;
  assign INTERNAL_BUS_SPEED_OUT = st.speed;
  assign BUS_WIDTH_16_OUT       = st.bus16;
  assign SOFT_RESET_OUT         = st.soft_rst;
  assign LOADING_OUT            = st.loading;
endmodule : hbcr_regs

// ===== tb/hbcr_regs_properties.sv
// checker for the config registers, sees only the top ports
// assumes one clock domain with the async active-low reset
`timescale 1ns/1ps
module hbcr_regs_properties (
  // clock, reset, bus
  input wire logic        SYS_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        CE_IN,
  input wire logic [15:0] BUS_ADDR_IN,
  input wire logic [15:0] BUS_WDATA_IN,
  input wire logic        BUS_WR_IN,
  input wire logic        BUS_HIT_OUT,
  // queue manager and chip state
  input wire logic        SWITCH_PAUSE_GLOBAL_IN,
  input wire logic        RX_FIFO_AT_THRESH_IN,
  input wire logic        TX_FRAME_BUSY_IN,
  input wire logic        TX_SEND_PAUSE_OUT,
  input wire logic        TX_PAD_ENABLE_OUT,
  input wire logic        TX_CHECKSUM_APPEND_OUT,
  input wire logic        TRANSMIT_RUN_OUT,
  input wire logic [2:0]  BURST_SIZE_OUT,
  input wire logic [1:0]  INTERNAL_BUS_SPEED_OUT,
  input wire logic        SOFT_RESET_OUT,
  input wire logic        LOADING_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // a frame in flight while running; writes excluded since they may stop it
  sequence s_busy_run;
    CE_IN && TRANSMIT_RUN_OUT && TX_FRAME_BUSY_IN && !SOFT_RESET_OUT && !BUS_WR_IN;
  endsequence
  AST_BOOT_DECODE: assert property (
    LOADING_OUT |-> BUS_HIT_OUT == (BUS_ADDR_IN[15:5] == 11'h018))
    else $error("decode during load not on default base");
  AST_PAUSE_GATE: assert property (
    TX_SEND_PAUSE_OUT |-> SWITCH_PAUSE_GLOBAL_IN && RX_FIFO_AT_THRESH_IN)
    else $error("pause without global enable and threshold");
  AST_RUN_HOLD: assert property (s_busy_run |=> TRANSMIT_RUN_OUT)
    else $error("run dropped in mid frame");
  AST_SOFT_STOP: assert property (
    CE_IN && SOFT_RESET_OUT && !BUS_WR_IN |=> !TRANSMIT_RUN_OUT)
    else $error("run kept under soft reset");
  AST_PAD_CAUSE: assert property (
    $rose(TX_PAD_ENABLE_OUT) |-> $past(BUS_WR_IN && BUS_HIT_OUT && BUS_WDATA_IN[2]))
    else $error("pad set without write");
  AST_CRC_CAUSE: assert property (
    $rose(TX_CHECKSUM_APPEND_OUT) |-> $past(BUS_WR_IN && BUS_HIT_OUT && BUS_WDATA_IN[1]))
    else $error("checksum set without write");
  AST_BURST_CAUSE: assert property (
    $changed(BURST_SIZE_OUT) |-> $past(BUS_WR_IN && BUS_HIT_OUT))
    else $error("burst changed without write");
  AST_SPEED_CAUSE: assert property (
    $changed(INTERNAL_BUS_SPEED_OUT) |-> $past(BUS_WR_IN && BUS_HIT_OUT) || $past(LOADING_OUT))
    else $error("speed changed without write or load");
endmodule : hbcr_regs_properties
bind hbcr_regs hbcr_regs_properties chk_u (.*);

// ===== tb/hbcr_rom_model.sv
// serial rom partner: answers read commands with a predictable word
// assumes 9 command bits in, then 16 data bits out msb first
`timescale 1ns/1ps
module hbcr_rom_model (
  // rom pins, seen from the rom
  input  wire logic cs_in,
  input  wire logic sk_in,
  input  wire logic di_in,
  output logic      do_out = 1'b0
);
  logic [4:0]  cnt = 0;
  logic [8:0]  cmd = 0;
  logic [15:0] wd;
  // word 0 gives base 0x0600, word 6 sets speed bit and clears width bit
  assign wd = 16'h0600 + 16'h0111 * 16'(cmd[5:0]);
  // command bits are taken at the clock rise while selected
  always @(posedge sk_in or negedge cs_in) begin
    if (!cs_in) cnt <= 0;
    else begin
      cnt <= cnt + 5'h01;
      if (cnt < 9) cmd <= {cmd[7:0], di_in};
    end
  end
  // deselected line flips so stale data never looks valid
  always @(negedge sk_in or negedge cs_in) begin
    if (!cs_in) do_out <= ~do_out;
    else if (cnt >= 9 && cnt <= 24) do_out <= wd[5'd24 - cnt];
  end
endmodule : hbcr_rom_model

// ===== tb/hbcr_regs_tb.sv
// bench for the config registers: register tasks and expected values
// assumes the rom model on the serial pins and a 10 MHz clock
`timescale 1ns/1ps
module hbcr_regs_tb import hbcr_pkg::*; ;
  logic SYS_CLK_IN = 0, RST_N_IN = 0, CE_IN = 1, ROM_LOAD_ENABLE_PIN_IN = 0, BUS_WR_IN = 0;
  logic BUS_RD_IN = 0, BUS_SYNC_XFER_IN = 0, BUS_ASYNC_XFER_IN = 0, TX_DONE_IN = 0;
  logic TX_MEM_TEST_DONE_IN = 0, TX_MEM_TEST_FAILED_IN = 0, RX_MEM_TEST_DONE_IN = 0;
  logic RX_MEM_TEST_FAILED_IN = 0, SWITCH_PAUSE_GLOBAL_IN = 0, RX_FIFO_AT_THRESH_IN = 0;
  logic TX_FRAME_BUSY_IN = 0, ROM_SERIAL_IN_PIN_IN, BUS_HIT_OUT, TRANSMIT_RUN_OUT;
  logic [15:0] BUS_ADDR_IN = 0, BUS_WDATA_IN = 0, base = 16'h0300, BUS_RDATA_OUT;
  logic [3:0]  BUS_BE_IN = 3;
  logic [5:0]  TX_DONE_TAG_IN = 0;
  logic [11:0] RX_HIGH_WATERMARK_OUT;
  logic [2:0]  BURST_SIZE_OUT;
  logic [1:0]  INTERNAL_BUS_SPEED_OUT;
  logic ROM_SERIAL_OUT_PIN_OUT, ROM_SERIAL_CLOCK_PIN_OUT, ROM_SELECT_PIN_OUT, TX_PAD_ENABLE_OUT;
  logic TX_SEND_PAUSE_OUT, TX_CHECKSUM_APPEND_OUT, BUS_WIDTH_16_OUT, SOFT_RESET_OUT, LOADING_OUT;
  int errors = 0, cmp_count = 0, cyc = 0;
  hbcr_regs dut_u (.*);
  hbcr_rom_model rom_u (.cs_in(ROM_SELECT_PIN_OUT), .sk_in(ROM_SERIAL_CLOCK_PIN_OUT),
    .di_in(ROM_SERIAL_OUT_PIN_OUT), .do_out(ROM_SERIAL_IN_PIN_IN));
  // clock and hang guard; load takes about 1300 cycles, so 20000 is ample
  always #50 SYS_CLK_IN = ~SYS_CLK_IN;
  always @(posedge SYS_CLK_IN) if (++cyc == 20000) begin
    errors++;
    print_verdict();
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one strobe held for one edge, then an idle edge so read data has landed
  task automatic acc(input logic w, input logic [3:0] o, input logic [15:0] d,
                     input logic [3:0] b = 4'h3);
    @(posedge SYS_CLK_IN);
    {BUS_ADDR_IN, BUS_WDATA_IN, BUS_BE_IN, BUS_WR_IN, BUS_RD_IN} <= {base | 16'(o), d, b, w, !w};
    @(posedge SYS_CLK_IN);
    {BUS_WR_IN, BUS_RD_IN} <= 2'b00;
    @(posedge SYS_CLK_IN);
  endtask : acc
  // select bank, then write d or read and compare against d
  task automatic ro(input logic w, input logic [5:0] k, input logic [3:0] o, input logic [15:0] d);
    acc(1, OFF_BANKSEL, {10'h000, k});
    acc(w, o, d);
    if (!w) chk(BUS_RDATA_OUT, d);
  endtask : ro
  task automatic do_reset(input logic s);
    @(posedge SYS_CLK_IN);
    // park the address on the rom's base so decode during the load is exercised
    {ROM_LOAD_ENABLE_PIN_IN, RST_N_IN, BUS_ADDR_IN} <= {s, 1'b0, 16'h0600};
    base = BASE_DEFAULT;
    repeat (3) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1;
    repeat (6) @(posedge SYS_CLK_IN);
    while (LOADING_OUT) @(posedge SYS_CLK_IN);
  endtask : do_reset
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    do_reset(0);
    ro(0, BANK_BUS, OFF_0, 16'h0300);
    ro(0, BANK_CHIP, OFF_8, 16'h0001);
    chk(RX_HIGH_WATERMARK_OUT, 16'hc00);
    ro(1, BANK_BUS, OFF_4, 16'h1000);
    chk(RX_HIGH_WATERMARK_OUT, 16'h800);
    acc(1, OFF_4, 16'h0000, 4'h5);
    chk(RX_HIGH_WATERMARK_OUT, 16'h800);
    {BUS_SYNC_XFER_IN, BUS_ASYNC_XFER_IN} <= 2'b11;
    @(posedge SYS_CLK_IN) {BUS_SYNC_XFER_IN, BUS_ASYNC_XFER_IN} <= 2'b00;
    ro(0, BANK_BUS, OFF_6, 16'hac00);
    acc(1, OFF_6, 16'h8400);
    acc(0, OFF_6, 0);
    chk(BUS_RDATA_OUT & 16'h8400, 0);
    for (int i = 0; i < 4; i++) begin
      ro(1, BANK_BUS, OFF_8, 16'(i * 2 + (i > 0)) << 12);
      chk(BURST_SIZE_OUT, 16'(i * 2 + (i > 0)));
      ro(1, BANK_CHIP, OFF_0, 16'(i));
      chk(INTERNAL_BUS_SPEED_OUT, 16'(i));
    end
    ro(1, BANK_STA, OFF_2, 16'h1234);
    ro(0, BANK_STA, OFF_2, 16'h1234);
    {TX_MEM_TEST_DONE_IN, TX_MEM_TEST_FAILED_IN,
     RX_MEM_TEST_DONE_IN, RX_MEM_TEST_FAILED_IN} <= 4'hd;
    ro(0, BANK_CHIP, OFF_4, 16'h1808);
    ro(1, BANK_CHIP, OFF_2, 16'h0015);
    chk({ROM_SERIAL_OUT_PIN_OUT, ROM_SERIAL_CLOCK_PIN_OUT, ROM_SELECT_PIN_OUT}, 5);
    acc(0, OFF_2, 0);
    chk(BUS_RDATA_OUT[3], ROM_SERIAL_IN_PIN_IN);
    // dropping select flips the model's data line, so both levels get read
    ro(1, BANK_CHIP, OFF_2, 16'h0014);
    chk({ROM_SERIAL_OUT_PIN_OUT, ROM_SERIAL_CLOCK_PIN_OUT, ROM_SELECT_PIN_OUT}, 4);
    acc(0, OFF_2, 0);
    chk(BUS_RDATA_OUT[3], ROM_SERIAL_IN_PIN_IN);
    ro(1, BANK_CHIP, OFF_2, 16'h0007);
    chk({ROM_SERIAL_OUT_PIN_OUT, ROM_SERIAL_CLOCK_PIN_OUT, ROM_SELECT_PIN_OUT}, 0);
    $display("test bus, error and chip registers done");
    {RX_FIFO_AT_THRESH_IN, TX_FRAME_BUSY_IN} <= 2'b11;
    ro(1, BANK_TXQ, OFF_0, 16'h000f);
    // run follows the control bit one edge after the write lands
    @(posedge SYS_CLK_IN);
    chk({TX_SEND_PAUSE_OUT, TX_PAD_ENABLE_OUT, TX_CHECKSUM_APPEND_OUT, TRANSMIT_RUN_OUT}, 7);
    SWITCH_PAUSE_GLOBAL_IN <= 1;
    ro(1, BANK_TXQ, OFF_0, 16'h0008);
    chk({TX_SEND_PAUSE_OUT, TRANSMIT_RUN_OUT}, 3);
    {TX_FRAME_BUSY_IN, TX_DONE_IN, TX_DONE_TAG_IN} <= 8'h6a;
    @(posedge SYS_CLK_IN) TX_DONE_IN <= 0;
    ro(0, BANK_TXQ, OFF_2, 16'h002a);
    chk(TRANSMIT_RUN_OUT, 0);
    ro(1, BANK_BUS, OFF_0, 16'h0540);
    base = 16'h0540;
    ro(1, BANK_TXQ, OFF_0, 16'h0001);
    ro(1, BANK_CHIP, OFF_6, 16'h0001);
    // run is forced low one edge after soft reset is set
    @(posedge SYS_CLK_IN);
    chk({SOFT_RESET_OUT, TRANSMIT_RUN_OUT}, 2);
    ro(0, BANK_BUS, OFF_0, 16'h0540);
    @(posedge SYS_CLK_IN) BUS_ADDR_IN <= 16'h0560;
    @(posedge SYS_CLK_IN) chk(BUS_HIT_OUT, 0);
    $display("test transmit, reset and decode done");
    do_reset(1);
    base = 16'h0600;
    ro(0, BANK_BUS, OFF_0, 16'h0600);
    for (int i = 0; i < 3; i++) ro(0, BANK_STA, 4'(i * 2), 16'h0711 + 16'h0111 * 16'(i));
    chk({INTERNAL_BUS_SPEED_OUT, BUS_WIDTH_16_OUT}, 6);
    $display("test rom boot load done");
    print_verdict();
  end
endmodule : hbcr_regs_tb
